// *** core/ubs_defines.svh ***
// Constants of the UART baud, status and frame-format block.
// Assumes byte-wide registers at the byte addresses below on a plain strobe port.
// Behaviour
// - Any write to the status register clears every status flag, unless a reception completes in the same cycle.
// - Framing error, bit 0, reflects start/stop check of each completed reception.
// - Framing, overrun and parity flags are held at zero in transmit mode.
// - Overrun, bit 1, sets when a character completes while the old one is unread.
// - The unread condition survives stop and restart of reception.
// - Parity error, bit 2, reflects parity check of every received character.
// - Buffer-full, bit 3, sets on transmit data write, clears on shift load.
// - Buffer-full is held at zero in receive mode.
// - Frame: start, 5 to 8 data, optional parity, one or two stops.
// - Bit order and line polarity are selectable for input and output.
// - Baud generator counts the clock chosen by the two clock-select bits.
// - Count reaches 4096 cycles per bit; register holds frequency/baud minus one.
// - Counts of 0007H or lower read back but count as 0008H.
// - Clock select: 00 slow, 01 doubled slow, 1x fast clock.
// - Length field: 00 eight, 01 seven, 10 six, 11 five data bits.
// - Parity field: 00 even, 01 odd, 1x no parity bit.
// - Mode bit 4 two stops, bit 5 negative logic, bit 6 MSB first.
`ifndef UBS_DEFINES_SVH
`define UBS_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define UBS_ADDR_BUF 16'hf290
`define UBS_ADDR_CTRL 16'hf291
`define UBS_ADDR_MODE_A 16'hf292
`define UBS_ADDR_MODE_B 16'hf293
`define UBS_ADDR_BAUD_LO 16'hf294
`define UBS_ADDR_BAUD_HI 16'hf295
`define UBS_ADDR_STAT 16'hf296

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define UBS_EN_BIT 0
`define UBS_IO_BIT 0
`define UBS_CK_LO_BIT 1
`define UBS_CK_HI_BIT 2
`define UBS_LG_LO_BIT 0
`define UBS_LG_HI_BIT 1
`define UBS_PT_LO_BIT 2
`define UBS_PT_HI_BIT 3
`define UBS_STP_BIT 4
`define UBS_NEG_BIT 5
`define UBS_DIR_BIT 6
`define UBS_FER_BIT 0
`define UBS_OER_BIT 1
`define UBS_PER_BIT 2
`define UBS_FUL_BIT 3
`define UBS_BAUD_RESET 16'h00ff
`define UBS_BYTE_RESET 8'h00

// ----------------------------------------------------------------
// Counter and frame sizes
// ----------------------------------------------------------------
`define UBS_DIV_W 12
`define UBS_MIN_DIV 12'h008
`define UBS_DATA_MAX 4'h8
`define UBS_SYNC_RX 0
`define UBS_SYNC_SLOW 1
`define UBS_SYNC_SLOW2X 2
`define UBS_SYNC_FAST 3
`define UBS_SYNC_W 4

`endif

// *** core/ubs_pkg.sv ***
// Types of the UART baud, status and frame-format block.
// Assumes ubs_defines.svh is on the include path.
`include "ubs_defines.svh"
package ubs_pkg;

    // Frame sequencer states, shared by transmit and receive
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ubs_state_t;

    // Register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ubs_bus_req_t;

    // Three-stage synchroniser state
    typedef struct packed {
        logic [`UBS_SYNC_W-1:0] s1;
        logic [`UBS_SYNC_W-1:0] s2;
        logic [`UBS_SYNC_W-1:0] s3;
        logic [`UBS_SYNC_W-1:0] q;
    } ubs_sync_st_t;

    // Baud generator state
    typedef struct packed {
        logic [`UBS_DIV_W-1:0] cnt;
    } ubs_baud_st_t;

    // Top-level state
    typedef struct packed {
        ubs_state_t st;
        logic [7:0] shreg;
        logic [2:0] bitcnt;
        logic stopcnt;
        logic par_acc;
        logic fer_acc;
        logic per_acc;
        logic [7:0] buf_data;
        logic en;
        logic [7:0] mode_a;
        logic [7:0] mode_b;
        logic [15:0] baud;
        logic fer;
        logic oer;
        logic per;
        logic ful;
        logic unread;
        logic txd;
        logic pin;
        logic [7:0] rdata;
        logic src_prev;
    } ubs_top_st_t;

endpackage : ubs_pkg

// *** core/ubs_sync.sv ***
// Three-flop synchroniser for pin-level inputs.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
`include "ubs_defines.svh"
module ubs_sync
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [`UBS_SYNC_W-1:0] d_in,
    output logic [`UBS_SYNC_W-1:0] q_out
);
    ubs_pkg::ubs_sync_st_t r_q;
    ubs_pkg::ubs_sync_st_t r_d;

    // ----------------------------------------------------------------
    // Next state: output follows once stages two and three agree
    // ----------------------------------------------------------------
    always_comb
    begin
        r_d = r_q;
        r_d.s1 = d_in;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        r_d.q = (r_q.s2 & ~(r_q.s2 ^ r_q.s3)) | (r_q.q & (r_q.s2 ^ r_q.s3));
    end

    // State register, idle lines read high
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            r_q <= '1;
        else
            r_q <= r_d;
    end

    assign q_out = r_q.q;

endmodule : ubs_sync

// *** core/ubs_baud_gen.sv ***
// Baud rate counter producing bit-end and mid-bit ticks.
// Assumes src_tick is one cycle per selected source clock rising edge.
`timescale 1ns/1ps
`include "ubs_defines.svh"
module ubs_baud_gen
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic src_tick,
    input wire logic restart,
    input wire logic [`UBS_DIV_W-1:0] divisor,
    output logic bit_tick,
    output logic mid_tick
);
    ubs_pkg::ubs_baud_st_t r_q;
    ubs_pkg::ubs_baud_st_t r_d;
    logic [`UBS_DIV_W-1:0] term;

    // Small counts behave as the minimum count
    assign term = (divisor < `UBS_MIN_DIV) ? `UBS_MIN_DIV : divisor;
    assign bit_tick = src_tick && (r_q.cnt == term);
    assign mid_tick = src_tick && (r_q.cnt == (term >> 1));

    // ----------------------------------------------------------------
    // Counter: term+1 source cycles per bit, reload at terminal count
    // ----------------------------------------------------------------
    always_comb
    begin
        r_d = r_q;
        if (restart)
            r_d.cnt = '0;
        else if (bit_tick)
            r_d.cnt = '0;
        else if (src_tick)
            r_d.cnt = r_q.cnt + 1'b1;
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            r_q <= '0;
        else
            r_q <= r_d;
    end

endmodule : ubs_baud_gen

// *** core/ubs_top.sv ***
// UART baud, status and frame-format block with half-duplex sequencer.
// Assumes a plain register port on ref_clk and asynchronous pins and source clocks.
`timescale 1ns/1ps
`include "ubs_defines.svh"
module ubs_top
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire ubs_pkg::ubs_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    input wire logic slow_clock,
    input wire logic slow_clock_x2,
    input wire logic fast_clock
);
    ubs_pkg::ubs_top_st_t r_q;
    ubs_pkg::ubs_top_st_t r_d;
    logic [`UBS_SYNC_W-1:0] sync_in;
    logic [`UBS_SYNC_W-1:0] sync_q;
    logic is_rx;
    logic [3:0] len;
    logic [2:0] last_idx;
    logic par_on;
    logic par_odd;
    logic two_stop;
    logic neg;
    logic msb;
    logic rx_bit;
    logic src_lvl;
    logic src_tick;
    logic restart;
    logic bit_tick;
    logic mid_tick;
    logic adv;

    // ----------------------------------------------------------------
    // Bit reversal within the data length
    // ----------------------------------------------------------------
    function automatic logic [7:0] ubs_order(input logic [7:0] d, input logic [3:0] n,
                                             input logic rev);
        logic [7:0] o;
        o = d;
        if (rev)
        begin
            o = '0;
            for (int i = 0; i < 8; i++)
            begin
                if (i < int'(n))
                    o[i] = d[3'(int'(n) - 1 - i)];
            end
        end
        return o;
    endfunction : ubs_order

    // ----------------------------------------------------------------
    // Input synchronisers and mode decode
    // ----------------------------------------------------------------
    assign sync_in = {fast_clock, slow_clock_x2, slow_clock, serial_in_pin};

    ubs_sync u_sync
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .d_in(sync_in),
        .q_out(sync_q)
    );

    // Mode field decode
    assign is_rx = r_q.mode_a[`UBS_IO_BIT];
    assign len = `UBS_DATA_MAX - {2'b00, r_q.mode_b[`UBS_LG_HI_BIT:`UBS_LG_LO_BIT]};
    assign last_idx = 3'(len - 4'h1);
    assign par_on = ~r_q.mode_b[`UBS_PT_HI_BIT];
    assign par_odd = r_q.mode_b[`UBS_PT_LO_BIT];
    assign two_stop = r_q.mode_b[`UBS_STP_BIT];
    assign neg = r_q.mode_b[`UBS_NEG_BIT];
    assign msb = r_q.mode_b[`UBS_DIR_BIT];
    assign rx_bit = sync_q[`UBS_SYNC_RX] ^ neg;

    // Baud source select: 00 slow, 01 doubled slow, 1x fast
    always_comb
    begin
        if (r_q.mode_a[`UBS_CK_HI_BIT])
            src_lvl = sync_q[`UBS_SYNC_FAST];
        else if (r_q.mode_a[`UBS_CK_LO_BIT])
            src_lvl = sync_q[`UBS_SYNC_SLOW2X];
        else
            src_lvl = sync_q[`UBS_SYNC_SLOW];
    end

    assign src_tick = src_lvl && !r_q.src_prev;
    assign adv = is_rx ? mid_tick : bit_tick;

    ubs_baud_gen u_baud
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .src_tick(src_tick),
        .restart(restart),
        .divisor(r_q.baud[`UBS_DIV_W-1:0]),
        .bit_tick(bit_tick),
        .mid_tick(mid_tick)
    );

    // ----------------------------------------------------------------
    // Next state: register port, frame sequencer, flag holds
    // ----------------------------------------------------------------
    always_comb
    begin
        r_d = r_q;
        restart = 1'b0;
        r_d.rdata = `UBS_BYTE_RESET;
        r_d.src_prev = src_lvl;

        // Register writes; sequencer below overrides, so its flag sets and its ful and en clears win
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                `UBS_ADDR_BUF:
                begin
                    if (!is_rx)
                    begin
                        r_d.buf_data = bus_req.wdata;
                        r_d.ful = 1'b1;
                    end
                end
                `UBS_ADDR_CTRL: r_d.en = bus_req.wdata[`UBS_EN_BIT];
                `UBS_ADDR_MODE_A: r_d.mode_a = bus_req.wdata;
                `UBS_ADDR_MODE_B: r_d.mode_b = bus_req.wdata;
                `UBS_ADDR_BAUD_LO: r_d.baud[7:0] = bus_req.wdata;
                `UBS_ADDR_BAUD_HI: r_d.baud[15:8] = bus_req.wdata;
                `UBS_ADDR_STAT:
                begin
                    r_d.fer = 1'b0;
                    r_d.oer = 1'b0;
                    r_d.per = 1'b0;
                    r_d.ful = 1'b0;
                end
                default: ;
            endcase
        end

        // Register reads, data valid in the next cycle only
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                `UBS_ADDR_BUF:
                begin
                    r_d.rdata = r_q.buf_data;
                    if (is_rx)
                        r_d.unread = 1'b0;
                end
                `UBS_ADDR_CTRL: r_d.rdata = {7'h00, r_q.en};
                `UBS_ADDR_MODE_A: r_d.rdata = r_q.mode_a;
                `UBS_ADDR_MODE_B: r_d.rdata = r_q.mode_b;
                `UBS_ADDR_BAUD_LO: r_d.rdata = r_q.baud[7:0];
                `UBS_ADDR_BAUD_HI: r_d.rdata = r_q.baud[15:8];
                `UBS_ADDR_STAT:
                begin
                    r_d.rdata[`UBS_FER_BIT] = r_q.fer;
                    r_d.rdata[`UBS_OER_BIT] = r_q.oer;
                    r_d.rdata[`UBS_PER_BIT] = r_q.per;
                    r_d.rdata[`UBS_FUL_BIT] = r_q.ful;
                end
                default: r_d.rdata = `UBS_BYTE_RESET;
            endcase
        end

        // Frame sequencer
        case (r_q.st)
            ubs_pkg::ST_IDLE:
            begin
                r_d.txd = 1'b1;
                if (r_q.en && !is_rx)
                begin
                    r_d.shreg = ubs_order(r_q.buf_data, len, msb);
                    r_d.ful = 1'b0;
                    r_d.txd = 1'b0;
                    r_d.st = ubs_pkg::ST_START;
                    restart = 1'b1;
                end
                else if (r_q.en && !rx_bit)
                begin
                    r_d.shreg = '0;
                    r_d.fer_acc = 1'b0;
                    r_d.per_acc = 1'b0;
                    r_d.st = ubs_pkg::ST_START;
                    restart = 1'b1;
                end
            end
            ubs_pkg::ST_START:
            begin
                if (adv)
                begin
                    r_d.bitcnt = '0;
                    r_d.st = ubs_pkg::ST_DATA;
                    if (is_rx)
                    begin
                        r_d.par_acc = 1'b0;
                        r_d.fer_acc = rx_bit;
                    end
                    else
                    begin
                        r_d.txd = r_q.shreg[0];
                        r_d.par_acc = r_q.shreg[0];
                        r_d.shreg = r_q.shreg >> 1;
                    end
                end
            end
            ubs_pkg::ST_DATA:
            begin
                if (adv)
                begin
                    if (is_rx)
                    begin
                        r_d.shreg = {rx_bit, r_q.shreg[7:1]};
                        r_d.par_acc = r_q.par_acc ^ rx_bit;
                    end
                    if (r_q.bitcnt == last_idx)
                    begin
                        r_d.stopcnt = 1'b0;
                        r_d.st = par_on ? ubs_pkg::ST_PAR : ubs_pkg::ST_STOP;
                        if (!is_rx)
                            r_d.txd = par_on ? (r_q.par_acc ^ par_odd) : 1'b1;
                    end
                    else
                    begin
                        r_d.bitcnt = r_q.bitcnt + 3'h1;
                        if (!is_rx)
                        begin
                            r_d.txd = r_q.shreg[0];
                            r_d.par_acc = r_q.par_acc ^ r_q.shreg[0];
                            r_d.shreg = r_q.shreg >> 1;
                        end
                    end
                end
            end
            ubs_pkg::ST_PAR:
            begin
                if (adv)
                begin
                    r_d.st = ubs_pkg::ST_STOP;
                    r_d.txd = 1'b1;
                    if (is_rx)
                        r_d.per_acc = rx_bit ^ r_q.par_acc ^ par_odd;
                end
            end
            ubs_pkg::ST_STOP:
            begin
                if (adv)
                begin
                    if (is_rx && !rx_bit)
                        r_d.fer_acc = 1'b1;
                    if (two_stop && !r_q.stopcnt)
                        r_d.stopcnt = 1'b1;
                    else if (is_rx)
                    begin
                        r_d.buf_data = ubs_order(r_q.shreg >> (`UBS_DATA_MAX - len), len, msb);
                        r_d.fer = r_d.fer_acc;
                        r_d.per = r_q.per_acc;
                        if (r_q.unread)
                            r_d.oer = 1'b1;
                        r_d.unread = 1'b1;
                        r_d.st = ubs_pkg::ST_IDLE;
                    end
                    else if (r_q.ful)
                    begin
                        r_d.shreg = ubs_order(r_q.buf_data, len, msb);
                        r_d.ful = 1'b0;
                        r_d.txd = 1'b0;
                        r_d.st = ubs_pkg::ST_START;
                    end
                    else
                    begin
                        r_d.en = 1'b0;
                        r_d.st = ubs_pkg::ST_IDLE;
                    end
                end
            end
            default: r_d.st = ubs_pkg::ST_IDLE;
        endcase

        // Stopping communication abandons a frame in flight
        if (!r_q.en && r_q.st != ubs_pkg::ST_IDLE)
        begin
            r_d.st = ubs_pkg::ST_IDLE;
            r_d.txd = 1'b1;
        end

        // Mode holds on the flags
        if (!is_rx)
        begin
            r_d.fer = 1'b0;
            r_d.oer = 1'b0;
            r_d.per = 1'b0;
        end
        else
        begin
            r_d.ful = 1'b0;
            r_d.txd = 1'b1;
        end
        r_d.pin = r_d.txd ^ neg;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            r_q <= '0;
            r_q.st <= ubs_pkg::ST_IDLE;
            r_q.baud <= `UBS_BAUD_RESET;
            r_q.txd <= 1'b1;
            r_q.pin <= 1'b1;
            r_q.src_prev <= 1'b1;
        end
        else
            r_q <= r_d;
    end

    // Outputs straight from flops
    assign rdata = r_q.rdata;
    assign serial_out_pin = r_q.pin;

endmodule : ubs_top

// *** bench/ubs_top_sva.sv ***
// Assertions on the register port and serial output of ubs_top.
// Assumes binding to ubs_top; shadows mode, enable and polarity from writes.
`timescale 1ns/1ps
`include "ubs_defines.svh"
module ubs_top_sva
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire ubs_pkg::ubs_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic slow_clock,
    input wire logic slow_clock_x2,
    input wire logic fast_clock
);
    logic rx_q;
    logic en_q;
    logic neg_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Shadow copies of receive mode, enable and line polarity as last written
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rx_q <= 1'b0;
            en_q <= 1'b0;
            neg_q <= 1'b0;
        end
        else if (bus_req.wr)
        begin
            if (bus_req.addr == `UBS_ADDR_MODE_A) rx_q <= bus_req.wdata[0];
            if (bus_req.addr == `UBS_ADDR_CTRL) en_q <= bus_req.wdata[0];
            if (bus_req.addr == `UBS_ADDR_MODE_B) neg_q <= bus_req.wdata[5];
        end
    end
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    sequence s_rd_stat;
        bus_req.rd && bus_req.addr == `UBS_ADDR_STAT;
    endsequence
    sequence s_wr_baud;
        bus_req.wr && bus_req.addr == `UBS_ADDR_BAUD_LO;
    endsequence
    rdata_idle_a: assert property (!bus_req.rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (bus_req.rd && (bus_req.addr < `UBS_ADDR_BUF ||
        bus_req.addr > `UBS_ADDR_STAT) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    baud_readback_a: assert property (s_wr_baud ##2 (bus_req.rd && bus_req.addr ==
        `UBS_ADDR_BAUD_LO) |=> rdata == $past(bus_req.wdata, 3))
        else $error("baud count read back differs");
    stat_clear_a: assert property ((bus_req.wr && bus_req.addr == `UBS_ADDR_STAT) ##[1:2]
        s_rd_stat |=> rdata == 8'h00)
        else $error("status not cleared by write");
    tx_err_zero_a: assert property (s_rd_stat ##0 !rx_q |=> rdata[2:0] == 3'h0)
        else $error("error flag set in transmit mode");
    rx_full_zero_a: assert property (s_rd_stat ##0 rx_q |=> !rdata[3])
        else $error("buffer full set in receive mode");
    full_set_a: assert property ((bus_req.wr && bus_req.addr == `UBS_ADDR_BUF && !rx_q
        && !en_q) ##2 s_rd_stat |=> rdata[3])
        else $error("buffer full not set by write");
    line_mark_a: assert property (((!en_q || rx_q) && $stable(neg_q))[*2]
        |-> serial_out_pin == !neg_q)
        else $error("idle line not at mark");
    tx_start_a: assert property (bus_req.wr && bus_req.addr == `UBS_ADDR_CTRL
        && bus_req.wdata[0] && !rx_q && !en_q |=> ##[0:3] serial_out_pin == neg_q)
        else $error("start bit not sent");
endmodule : ubs_top_sva

bind ubs_top ubs_top_sva i_sva (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .slow_clock(slow_clock), .slow_clock_x2(slow_clock_x2), .fast_clock(fast_clock));

// *** bench/ubs_peer.sv ***
// Remote serial peer: builds frames and sends them on the receive line.
// Assumes one bit lasts a whole number of ref_clk cycles.
`timescale 1ns/1ps
module ubs_peer
(
    input wire logic ref_clk,
    output logic serial_in_pin
);
    initial serial_in_pin = 1'b1;
    // Logical frame bits in time order; mb is the mode_b value
    function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] mb,
        output int n);
        int len;
        logic [11:0] f;
        len = 8 - mb[1:0];
        f = 12'h000;
        n = 1;
        for (int i = 0; i < len; i++)
        begin
            f[n] = mb[6] ? d[len - 1 - i] : d[i];
            n = n + 1;
        end
        if (!mb[3])
        begin
            f[n] = ^(d & (8'hff >> (8 - len))) ^ mb[2];
            n = n + 1;
        end
        f[n] = 1'b1;
        f[n + 1] = 1'b1;
        n = n + 1 + mb[4];
        return f;
    endfunction : frame
    // Send one frame, flip marks bits to corrupt, then rest at mark
    task automatic send(input logic [7:0] d, input logic [7:0] mb, input int per,
        input logic [11:0] flip);
        logic [11:0] f;
        int n;
        f = frame(d, mb, n) ^ flip;
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            serial_in_pin <= f[i] ^ mb[5];
            repeat (per - 1) @(posedge ref_clk);
        end
        mark(mb[5]);
    endtask : send
    task automatic mark(input logic neg);
        @(posedge ref_clk);
        serial_in_pin <= ~neg;
    endtask : mark
endmodule : ubs_peer

// *** bench/tb_ubs_top.sv ***
// Self-checking bench for ubs_top with a remote serial peer.
// Assumes the source clocks are free running and unrelated to ref_clk.
`timescale 1ns/1ps
`include "ubs_defines.svh"
module tb_ubs_top;
    logic ref_clk;
    logic rst;
    logic serial_in_pin;
    logic serial_out_pin;
    logic slow_clock;
    logic slow_clock_x2;
    logic fast_clock;
    logic [7:0] rdata;
    ubs_pkg::ubs_bus_req_t bus_req;
    int fail_count;
    int total_checks;
    ubs_top i_dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
        .slow_clock(slow_clock), .slow_clock_x2(slow_clock_x2), .fast_clock(fast_clock));
    ubs_peer i_peer (.ref_clk(ref_clk), .serial_in_pin(serial_in_pin));
    // ----------------------------------------
    // Clocks: ref 20 ns, sources 4, 16 and 32 cycles
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        fast_clock = 1'b0;
        #7;
        forever #40 fast_clock = ~fast_clock;
    end
    initial
    begin
        slow_clock_x2 = 1'b0;
        #7;
        forever #160 slow_clock_x2 = ~slow_clock_x2;
    end
    initial
    begin
        slow_clock = 1'b0;
        #7;
        forever #320 slow_clock = ~slow_clock;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask : rchk
    // Counts cycles until the line shows lvl; a hang ends the run
    task automatic wait_line(input logic lvl, output int n);
        n = 0;
        while (serial_out_pin !== lvl)
        begin
            @(posedge ref_clk);
            #1 n++;
            if (n > 5000)
            begin
                fail_count++;
                tally_and_finish();
            end
        end
    endtask : wait_line
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rchk(`UBS_ADDR_BAUD_LO, 8'hff);
        rchk(`UBS_ADDR_BAUD_HI, 8'h00);
        rchk(`UBS_ADDR_STAT, 8'h00);
        rchk(16'hf297, 8'h00);
        wr(`UBS_ADDR_BAUD_HI, 8'h0f);
        rchk(`UBS_ADDR_BAUD_HI, 8'h0f);
        wr(`UBS_ADDR_BAUD_HI, 8'h00);
        wr(`UBS_ADDR_BAUD_LO, 8'h05);
        rchk(`UBS_ADDR_BAUD_LO, 8'h05);
    endtask : t_regs
    // High data bit width for every clock select, count 5 acting as 8
    task automatic t_bit_time;
        int per [4] = '{32, 16, 4, 4};
        int n;
        for (int s = 0; s < 4; s++)
        begin
            wr(`UBS_ADDR_MODE_A, 8'(s << 1));
            rchk(`UBS_ADDR_STAT, 8'h00);
            wr(`UBS_ADDR_BUF, 8'h02);
            wr(`UBS_ADDR_CTRL, 8'h01);
            wait_line(1'b0, n);
            wait_line(1'b1, n);
            wait_line(1'b0, n);
            chk(16'(n), 16'(9 * per[s]));
            wr(`UBS_ADDR_CTRL, 8'h00);
        end
    endtask : t_bit_time
    // Seven bits, odd parity, two stops, negative logic, MSB first
    task automatic t_tx;
        logic [11:0] got;
        int n;
        wr(`UBS_ADDR_MODE_A, 8'h04);
        wr(`UBS_ADDR_MODE_B, 8'h75);
        wr(`UBS_ADDR_BUF, 8'h4b);
        rchk(`UBS_ADDR_STAT, 8'h08);
        wr(`UBS_ADDR_CTRL, 8'h01);
        wait_line(1'b1, n);
        got = 12'h000;
        repeat (18) @(posedge ref_clk);
        for (int i = 0; i < 11; i++)
        begin
            #1 got[i] = ~serial_out_pin;
            repeat (36) @(posedge ref_clk);
        end
        chk({4'h0, got}, {4'h0, i_peer.frame(8'h4b, 8'h75, n)});
        rchk(`UBS_ADDR_STAT, 8'h00);
        rchk(`UBS_ADDR_CTRL, 8'h00);
        wr(`UBS_ADDR_MODE_B, 8'h00);
    endtask : t_tx
    // Good frame, restart, bad frame: overrun, parity and framing errors
    task automatic t_rx;
        wr(`UBS_ADDR_MODE_A, 8'h05);
        wr(`UBS_ADDR_CTRL, 8'h01);
        i_peer.send(8'h3c, 8'h00, 36, 12'h000);
        repeat (5) @(posedge ref_clk);
        rchk(`UBS_ADDR_STAT, 8'h00);
        wr(`UBS_ADDR_CTRL, 8'h00);
        wr(`UBS_ADDR_CTRL, 8'h01);
        i_peer.send(8'ha7, 8'h00, 36, 12'h600);
        repeat (5) @(posedge ref_clk);
        rchk(`UBS_ADDR_STAT, 8'h07);
        rchk(`UBS_ADDR_BUF, 8'ha7);
        wr(`UBS_ADDR_BUF, 8'h55);
        rchk(`UBS_ADDR_BUF, 8'ha7);
        rchk(`UBS_ADDR_STAT, 8'h07);
        wr(`UBS_ADDR_CTRL, 8'h00);
        wr(`UBS_ADDR_MODE_A, 8'h04);
        rchk(`UBS_ADDR_STAT, 8'h00);
        wr(`UBS_ADDR_BUF, 8'h5a);
        wr(`UBS_ADDR_STAT, 8'h5a);
        rchk(`UBS_ADDR_STAT, 8'h00);
        i_peer.mark(1'b1);
        wr(`UBS_ADDR_MODE_A, 8'h05);
        wr(`UBS_ADDR_MODE_B, 8'h6b);
        wr(`UBS_ADDR_CTRL, 8'h01);
        i_peer.send(8'h16, 8'h6b, 36, 12'h000);
        repeat (5) @(posedge ref_clk);
        rchk(`UBS_ADDR_BUF, 8'h16);
        rchk(`UBS_ADDR_STAT, 8'h00);
    endtask : t_rx
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        fail_count = 0;
        total_checks = 0;
        bus_req = '0;
        rst = 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_bit_time();
        t_tx();
        t_rx();
        tally_and_finish();
    end
endmodule : tb_ubs_top
